// ===== emb_pkg.sv
// constants, field layouts and carrier types of the memory bus config block
package emb_pkg;
  // ---------------------------------------------------------------
  // register map: printed offsets are indices, byte address is x4
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_BUS_FORMAT = 8'hF5;
  localparam logic [7:0] IDX_SEG_STRETCH = 8'hF6;
  localparam logic [7:0] IDX_WAIT_CTRL = 8'hFC;
  localparam logic [11:0] ADDR_BUS_FORMAT = {2'h0, IDX_BUS_FORMAT, 2'h0};
  localparam logic [11:0] ADDR_SEG_STRETCH = {2'h0, IDX_SEG_STRETCH, 2'h0};
  localparam logic [11:0] ADDR_WAIT_CTRL = {2'h0, IDX_WAIT_CTRL, 2'h0};
  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BUS_FORMAT = 8'h80;
  localparam logic [7:0] RST_SEG_STRETCH = 8'h1F;
  localparam logic [7:0] RST_WAIT_CTRL = 8'h7F;
  localparam logic [7:0] WMASK_BUS_FORMAT = 8'h76;
  localparam logic [7:0] WMASK_SEG_STRETCH = 8'h7F;
  localparam logic [7:0] WMASK_WAIT_CTRL = 8'h7F;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BF_MODE_BIT = 6;
  localparam int BF_SECOND_STROBE_ENABLE_BIT = 5;
  localparam int BF_STROBE_ALT_FUNCTION_BIT = 4;
  localparam int BF_TOGGLE_BIT = 2;
  localparam int BF_HIDRV_BIT = 1;
  localparam int SS_SEGSAVE_BIT = 6;
  localparam int SS_REMAP_BIT = 5;
  localparam int SS_MEMORY_SELECT_BIT_BIT = 4;
  localparam int SS_LAS_LSB = 2;
  localparam int SS_UAS_LSB = 0;
  localparam int WC_WDG_BIT = 6;
  localparam int WC_UDS_LSB = 3;
  localparam int WC_LDS_LSB = 0;
  localparam int BLOCK_SEL_BIT = 21;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} emb_state_t;
  // as is the address strobe pin level: active low, or active high latch
  typedef struct packed {
    logic as;
    logic ds_n;
    logic ds2_n;
    logic rw_n;
  } emb_strobe_t;
  typedef struct packed {
    logic [21:0] addr;
    logic wr;
    logic ext;
    logic [7:0] wdata;
  } emb_req_t;
endpackage

// ===== emb_bus_config.sv
// external memory bus configuration registers and cycle strobe generator
// Functional notes
// (RULE1) format bit set: address strobe becomes active-high latch enable
// (RULE2) format bit set: data strobe is output enable, data sampled on rise
// (RULE3) format bit set: read/write pin is write enable, low during write
// (RULE4) format bit clear: classic active-low strobe format on all three pins
// (RULE5) second strobe disabled: primary strobe for all, second held high
// (RULE6) second strobe enabled: lower block uses second, upper holds it high
// (RULE7) strobe alternate-function bit enables the address strobe output
// (RULE8) toggle bit clear: pins change only on external accesses
// (RULE9) toggle set, protection off: pins toggle on internal, primary not
// (RULE10) segment save clear: interrupt pushes only counter and flags
// (RULE11) segment save set: interrupt also pushes and reloads segment pointer
// (RULE12) remap bit swaps page pointers with port data registers
// (RULE13) software keeps memory select at 1 and reserved bit 3 clear; the code uses bit 3 as the top bit of the lower address stretch field, reset 1
// (RULE14) lower block address strobe stretched 0 to 3 cycles, reset 3
// (RULE15) upper block address strobe stretched 0 to 3 cycles, reset 3
// (RULE16) software never writes stretch register from an interrupt routine
// (RULE17) wait control bit 7 always reads zero
// (RULE18) clearing watchdog enable bit selects watchdog mode
// (RULE19) upper block data strobe stretched 0 to 7 cycles, reset 7
// (RULE20) lower block data strobe stretched 0 to 7 cycles, reset 7
// (RULE21) data stretch counted in internal clock periods
// (RULE22) software should zero data stretch counts for fast memories
// (RULE23) sampled external wait adds one cycle to the current phase
// (RULE24) each cycle is an address phase then a data phase
// (RULE25) programmed stretch comes before external wait cycles, both add
//
// The implementer's own choice: register access over AXI4-Lite.
module emb_bus_config
  import emb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // axi4-lite register port
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core memory request port
  input wire logic mem_req,
  input wire emb_req_t mem_req_data,
  input wire logic internal_protect_off,
  output logic mem_done,
  output logic [7:0] mem_rdata,
  // external wait
  input wire logic wait_n,
  input wire logic external_wait_enable,
  // memory pins
  output emb_strobe_t strobe_pins,
  output logic [21:8] addr_hi,
  output logic [7:0] ad_out,
  output logic ad_oe,
  input wire logic [7:0] ad_in,
  // configuration levels to the rest of the chip
  output logic strobe_alt_function,
  output logic high_drive_select,
  output logic segment_save_enable,
  output logic page_pointer_remap,
  output logic memory_select_bit,
  output logic watchdog_enable_bit
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] merge(input logic [7:0] q,
      input logic [7:0] wd, input logic [7:0] m);
    merge = (wd & m) | (q & ~m);
  endfunction

  function automatic logic [7:0] reg_read(input logic [11:0] a,
      input logic [7:0] bf, input logic [7:0] ss, input logic [7:0] wc);
    case (a)
      ADDR_BUS_FORMAT: reg_read = bf;
      ADDR_SEG_STRETCH: reg_read = ss;
      ADDR_WAIT_CTRL: reg_read = {1'b0, wc[6:0]}; // RULE17
      default: reg_read = 8'h00;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_BUS_FORMAT) || (a == ADDR_SEG_STRETCH) ||
                (a == ADDR_WAIT_CTRL);
  endfunction

  function automatic emb_strobe_t strobe_f(input emb_state_t st,
      input emb_req_t r, input logic [7:0] bf, input logic tog);
    logic mc;
    logic drive;
    logic t1;
    logic t2;
    logic rd_gate;
    logic lower;
    logic split;
    mc = bf[BF_MODE_BIT];
    drive = r.ext | tog; // RULE8 RULE9
    t1 = (st == ST_ADDR) & drive;
    t2 = (st == ST_DATA) & drive;
    // latch format strobes only reads; classic strobes both directions
    rd_gate = mc ? ~r.wr : 1'b1; // RULE2 RULE4
    lower = ~r.addr[BLOCK_SEL_BIT];
    split = bf[BF_SECOND_STROBE_ENABLE_BIT];
    strobe_f.as = mc ? t1 : ~t1; // RULE1 RULE4
    strobe_f.rw_n = mc ? ~(t2 & r.wr) // RULE3
                       : ~((st != ST_IDLE) & drive & r.wr); // RULE4
    // primary strobe never moves on an internal access
    strobe_f.ds_n = ~(t2 & r.ext & rd_gate & ~(split & lower)); // RULE5 RULE9
    strobe_f.ds2_n = ~(t2 & rd_gate & split & lower); // RULE5 RULE6
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] bus_format_config_q;
  logic [7:0] segment_and_strobe_stretch_q;
  logic [7:0] wait_cycle_control_q;
  logic aw_full_q;
  logic w_full_q;
  logic [11:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire aw_take = s_axi_awvalid & ~aw_full_q;
  wire w_take = s_axi_wvalid & ~w_full_q;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_ok = do_write & w_lane_q & is_mapped(aw_addr_q);
  wire ar_take = s_axi_arvalid & ~rvalid_q;

  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_format_config_q <= RST_BUS_FORMAT;
      segment_and_strobe_stretch_q <= RST_SEG_STRETCH;
      wait_cycle_control_q <= RST_WAIT_CTRL;
    end else if (wr_ok) begin
      case (aw_addr_q)
        ADDR_BUS_FORMAT: bus_format_config_q <=
          merge(bus_format_config_q, w_data_q, WMASK_BUS_FORMAT);
        ADDR_SEG_STRETCH: segment_and_strobe_stretch_q <=
          merge(segment_and_strobe_stretch_q, w_data_q, WMASK_SEG_STRETCH);
        ADDR_WAIT_CTRL: wait_cycle_control_q <=
          merge(wait_cycle_control_q, w_data_q, WMASK_WAIT_CTRL);
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, reg_read(s_axi_araddr, bus_format_config_q,
        segment_and_strobe_stretch_q, wait_cycle_control_q)};
      rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration levels
  // ---------------------------------------------------------------
  assign strobe_alt_function = bus_format_config_q[BF_STROBE_ALT_FUNCTION_BIT]; // RULE7
  assign high_drive_select = bus_format_config_q[BF_HIDRV_BIT];
  // the core reads these to pick its stack frame and register page map
  assign segment_save_enable =
    segment_and_strobe_stretch_q[SS_SEGSAVE_BIT]; // RULE10 RULE11
  assign page_pointer_remap =
    segment_and_strobe_stretch_q[SS_REMAP_BIT]; // RULE12
  assign memory_select_bit = segment_and_strobe_stretch_q[SS_MEMORY_SELECT_BIT_BIT];
  assign watchdog_enable_bit = wait_cycle_control_q[WC_WDG_BIT]; // RULE18

  // ---------------------------------------------------------------
  // memory cycle sequencer
  // ---------------------------------------------------------------
  emb_state_t state_q;
  emb_state_t state_d;
  emb_req_t req_q;
  emb_req_t req_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic done_q;
  logic [7:0] rdat_q;
  emb_strobe_t pins_q;
  logic [21:8] addr_hi_q;
  logic [7:0] ad_out_q;
  logic ad_oe_q;

  wire [1:0] las = segment_and_strobe_stretch_q[SS_LAS_LSB +: 2];
  wire [1:0] uas = segment_and_strobe_stretch_q[SS_UAS_LSB +: 2];
  wire [2:0] uds = wait_cycle_control_q[WC_UDS_LSB +: 3];
  wire [2:0] lds = wait_cycle_control_q[WC_LDS_LSB +: 3];
  wire toggle_eff = bus_format_config_q[BF_TOGGLE_BIT] & internal_protect_off;
  wire wait_hold = external_wait_enable & ~wait_n & req_q.ext; // RULE23
  wire new_upper = mem_req_data.addr[BLOCK_SEL_BIT];
  wire [2:0] as_load = ~mem_req_data.ext ? 3'h0 :
    (new_upper ? {1'b0, uas} : {1'b0, las}); // RULE14 RULE15
  // stretch counts run on ref_clk, which is the internal clock
  wire [2:0] ds_load = ~req_q.ext ? 3'h0 :
    (req_q.addr[BLOCK_SEL_BIT] ? uds : lds); // RULE19 RULE20 RULE21
  // the programmed count drains first; wait is looked at only at zero
  wire phase_end = (cnt_q == 3'h0) & ~wait_hold; // RULE25
  wire drive_d = req_d.ext | toggle_eff;

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (mem_req) begin
          state_d = ST_ADDR; // RULE24
          req_d = mem_req_data;
          cnt_d = as_load;
        end
      end
      ST_ADDR: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else if (phase_end) begin
          state_d = ST_DATA; // RULE24
          cnt_d = ds_load;
        end
      end
      ST_DATA: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else if (phase_end) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      cnt_q <= cnt_d;
      done_q <= (state_q == ST_DATA) & (state_d == ST_IDLE);
      // sampled on the edge that ends the data phase (strobe rise)
      if ((state_q == ST_DATA) && (state_d == ST_IDLE) && !req_q.wr) begin
        rdat_q <= ad_in; // RULE2
      end
    end
  end

  // pins follow the next state so they line up with state_q
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins_q <= strobe_f(ST_IDLE, '0, RST_BUS_FORMAT, 1'b0);
      addr_hi_q <= 14'h0000;
      ad_out_q <= 8'h00;
      ad_oe_q <= 1'b0;
    end else begin
      pins_q <= strobe_f(state_d, req_d, bus_format_config_q, toggle_eff);
      if (drive_d && state_d == ST_ADDR) begin // RULE8
        addr_hi_q <= req_d.addr[21:8];
        ad_out_q <= req_d.addr[7:0]; // RULE1
        ad_oe_q <= 1'b1;
      end else if (drive_d && state_d == ST_DATA) begin
        ad_out_q <= req_d.wdata; // RULE3
        ad_oe_q <= req_d.wr;
      end
    end
  end

  assign strobe_pins = pins_q;
  assign addr_hi = addr_hi_q;
  assign ad_out = ad_out_q;
  assign ad_oe = ad_oe_q;
  assign mem_done = done_q;
  assign mem_rdata = rdat_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [3:0] ph_cyc_q;
  logic wait_seen_q;
  always_ff @(posedge ref_clk) begin
    if (srst || state_d != state_q) begin
      ph_cyc_q <= 4'h0;
      wait_seen_q <= 1'b0;
    end else begin
      ph_cyc_q <= ph_cyc_q + 4'h1;
      wait_seen_q <= wait_seen_q | ((cnt_q == 3'h0) & wait_hold);
    end
  end
  wire ph_exit = (state_q != ST_IDLE) && (state_d != state_q);
  wire mc_now = bus_format_config_q[BF_MODE_BIT];

  a_ale_high: assert property (@(posedge ref_clk) disable iff (srst) // RULE1
    $rose(state_q == ST_ADDR) && req_q.ext && mc_now && $stable(mc_now)
    |-> strobe_pins.as)
    else $error("latch enable not high in address phase");
  a_oen_read: assert property (@(posedge ref_clk) disable iff (srst) // RULE2
    state_q == ST_DATA && req_q.ext && !req_q.wr && $past(mc_now)
    && $past(state_q) == ST_DATA |-> !(strobe_pins.ds_n && strobe_pins.ds2_n))
    else $error("output enable not low during read data phase");
  a_wen_write: assert property (@(posedge ref_clk) disable iff (srst) // RULE3
    $past(mc_now) && state_q == ST_IDLE |-> strobe_pins.rw_n)
    else $error("write enable low outside data phase");
  a_classic_as: assert property (@(posedge ref_clk) disable iff (srst) // RULE4
    !$past(mc_now) && state_q == ST_ADDR && req_q.ext
    && $past(state_q) == ST_ADDR |-> !strobe_pins.as)
    else $error("classic address strobe not low");
  a_ds2_idle: assert property (@(posedge ref_clk) disable iff (srst) // RULE5
    !$past(bus_format_config_q[BF_SECOND_STROBE_ENABLE_BIT]) |-> strobe_pins.ds2_n)
    else $error("second strobe moved while disabled");
  a_ds_lower: assert property (@(posedge ref_clk) disable iff (srst) // RULE6
    $past(bus_format_config_q[BF_SECOND_STROBE_ENABLE_BIT]) && state_q != ST_IDLE
    && !req_q.addr[BLOCK_SEL_BIT] |-> strobe_pins.ds_n)
    else $error("primary strobe moved on lower block access");
  a_int_ds_high: assert property (@(posedge ref_clk) disable iff (srst) // RULE9
    state_q != ST_IDLE && !req_q.ext |-> strobe_pins.ds_n)
    else $error("primary strobe toggled on internal access");
  a_int_quiet: assert property (@(posedge ref_clk) disable iff (srst) // RULE8
    state_q == ST_ADDR && !req_q.ext && !$past(toggle_eff)
    |-> $stable(addr_hi) && $stable(strobe_pins))
    else $error("pins moved on internal access");
  a_las_len: assert property (@(posedge ref_clk) disable iff (srst) // RULE14
    ph_exit && state_q == ST_ADDR && req_q.ext && !wait_seen_q
    && !req_q.addr[BLOCK_SEL_BIT] && $stable(las) |-> ph_cyc_q == {2'h0, las})
    else $error("lower address phase length wrong");
  a_uas_len: assert property (@(posedge ref_clk) disable iff (srst) // RULE15
    ph_exit && state_q == ST_ADDR && req_q.ext && !wait_seen_q
    && req_q.addr[BLOCK_SEL_BIT] && $stable(uas) |-> ph_cyc_q == {2'h0, uas})
    else $error("upper address phase length wrong");
  a_uds_len: assert property (@(posedge ref_clk) disable iff (srst) // RULE19
    ph_exit && state_q == ST_DATA && req_q.ext && !wait_seen_q
    && req_q.addr[BLOCK_SEL_BIT] && $stable(uds) |-> ph_cyc_q == {1'h0, uds})
    else $error("upper data phase length wrong");
  a_lds_len: assert property (@(posedge ref_clk) disable iff (srst) // RULE20
    ph_exit && state_q == ST_DATA && req_q.ext && !wait_seen_q
    && !req_q.addr[BLOCK_SEL_BIT] && $stable(lds) |-> ph_cyc_q == {1'h0, lds})
    else $error("lower data phase length wrong");
  a_wait_hold: assert property (@(posedge ref_clk) disable iff (srst) // RULE23
    state_q != ST_IDLE && cnt_q == 3'h0 && wait_hold |=> $stable(state_q))
    else $error("phase ended while wait active");
  a_wcr_bit7: assert property (@(posedge ref_clk) disable iff (srst) // RULE17
    ar_take && s_axi_araddr == ADDR_WAIT_CTRL |=> !s_axi_rdata[7])
    else $error("wait control bit 7 read as one");
endmodule

// ===== emb_mem_model.sv
// external memory with address latch on the multiplexed bus
module emb_mem_model
  import emb_pkg::*;
(
  // clock and format
  input wire logic ref_clk,
  input wire logic latch_fmt,
  // memory pins
  input wire emb_strobe_t strobe_pins,
  input wire logic [7:0] ad_out,
  output logic [7:0] ad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] a_q;
  logic [7:0] last_q = 8'h5A;
  wire sel_n = strobe_pins.ds_n & strobe_pins.ds2_n;
  wire rd = !sel_n && (latch_fmt || strobe_pins.rw_n);
  wire wr = !strobe_pins.rw_n && (latch_fmt || !sel_n);
  // the latch loads the low byte while the strobe is active and holds it once inactive
  always @(posedge ref_clk) begin
    if (strobe_pins.as === latch_fmt) a_q <= ad_out;
    if (wr) mem[a_q] <= ad_out;
    last_q <= ad_in;
  end
  // no pull on the bus: a released bus shows a moving pattern
  assign ad_in = rd ? mem[a_q] : ~last_q;
endmodule

// ===== external_memory_bus_config_tb_top.sv
// self-checking bench of the memory bus config block
module external_memory_bus_config_tb_top;
  import emb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = '0, srst = '1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_done, ad_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mem_req = '0, internal_protect_off = '0;
  emb_req_t mem_req_data = '0;
  logic [7:0] mem_rdata, ad_out, ad_in;
  logic wait_n = '1, external_wait_enable = '0;
  emb_strobe_t strobe_pins;
  logic [21:8] addr_hi;
  logic strobe_alt_function, high_drive_select, segment_save_enable;
  logic page_pointer_remap, memory_select_bit, watchdog_enable_bit;
  logic fmt = '0, second_strobe_enable = '0, tog = '0;
  logic [1:0] las = 2'h3, uas = 2'h3;
  logic [2:0] lds = 3'h7, uds = 3'h7;
  logic [21:0] a;
  logic [7:0] d;
  logic [8:0] m;
  int failures = 0, checked = 0, seed = 22;
  logic [31:0] exp_r[$], exp_b[$];
  logic [8:0] exp_m[$];

  emb_bus_config u_dut (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_req_data,
    .internal_protect_off, .mem_done, .mem_rdata, .wait_n,
    .external_wait_enable, .strobe_pins, .addr_hi, .ad_out, .ad_oe, .ad_in,
    .strobe_alt_function, .high_drive_select, .segment_save_enable,
    .page_pointer_remap, .memory_select_bit, .watchdog_enable_bit);
  emb_mem_model u_mem (.ref_clk, .latch_fmt(fmt), .strobe_pins, .ad_out,
    .ad_in);

  always #5 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // comparison, verdict and bus tasks
  // ------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic axi_wr(logic [11:0] ad, logic [7:0] v, logic [1:0] rs);
    logic aw, w, b = '0;
    exp_b.push_back({30'h0, rs});
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    while (!b) begin
      @(negedge ref_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= '0;
      if (w) s_axi_wvalid <= '0;
    end
    // bready stays up so a following call never drives it twice in a step
  endtask

  task automatic axi_rd(logic [11:0] ad, logic [7:0] e);
    logic ar, r = '0;
    exp_r.push_back({24'h0, e});
    s_axi_araddr <= ad;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    while (!r) begin
      @(negedge ref_clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= '0;
    end
  endtask

  task automatic cfg();
    axi_wr(ADDR_BUS_FORMAT, {1'h0, fmt, second_strobe_enable, 2'h0, tog, 2'h0}, RESP_OKAY);
    axi_wr(ADDR_SEG_STRETCH, {4'h1, las, uas}, RESP_OKAY);
    axi_wr(ADDR_WAIT_CTRL, {2'h1, uds, lds}, RESP_OKAY);
  endtask

  // one memory cycle; cycle and strobe counts follow the shadow config
  task automatic mem_acc(logic [21:0] ad, logic wr, logic ext,
                         logic [7:0] v, logic wt);
    int n = 0, as_c = 0, ds_c = 0, ds2_c = 0;
    logic up = ad[BLOCK_SEL_BIT];
    int st_a = ext ? int'(up ? uas : las) + wt : 0;
    int st_d = ext ? int'(up ? uds : lds) : 0;
    logic act = ext && (!fmt || !wr);
    logic two = second_strobe_enable && !up;
    logic pins = ext || (tog && internal_protect_off);
    exp_m.push_back({!wr && ext, v});
    mem_req_data <= '{ad, wr, ext, v};
    mem_req <= '1;
    do begin
      @(posedge ref_clk);
      mem_req <= '0;
      n++;
      wait_n <= !(wt && n == 1);
      @(negedge ref_clk);
      as_c += (strobe_pins.as === fmt);
      ds_c += (strobe_pins.ds_n === 1'h0);
      ds2_c += (strobe_pins.ds2_n === 1'h0);
    end while (mem_done !== 1'h1 && n < 100);
    @(posedge ref_clk);
    check("cycles", n, 3 + st_a + st_d);
    check("as", as_c, pins ? 1 + st_a : 0);
    check("ds", ds_c, act && !two ? 1 + st_d : 0);
    if (ext) check("ds2", ds2_c, act && two ? 1 + st_d : 0);
    if (pins) check("addr_hi", addr_hi, ad[21:8]);
    if (pins) check("ad_oe", ad_oe, wr);
  endtask

  // ------------------------------------------------------------
  // result monitor and sequence
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", s_axi_bresp, exp_b.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      check("rdata", s_axi_rdata, exp_r.pop_front());
      check("rresp", s_axi_rresp, RESP_OKAY);
    end
    if (mem_done === 1'h1) begin
      m = exp_m.pop_front();
      if (m[8]) check("mem_rdata", mem_rdata, m[7:0]);
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= '0;
    @(posedge ref_clk);
    axi_rd(ADDR_BUS_FORMAT, 8'h80);
    axi_rd(ADDR_SEG_STRETCH, 8'h1F);
    axi_rd(ADDR_WAIT_CTRL, 8'h7F);
    mem_acc(22'h200010, '1, '1, 8'hA5, '0);
    mem_acc(22'h000011, '1, '1, 8'h5A, '0);
    mem_acc(22'h200010, '0, '1, 8'hA5, '0);
    $display("reset test done");
    axi_wr(ADDR_WAIT_CTRL, 8'hBF, RESP_OKAY);
    axi_rd(ADDR_WAIT_CTRL, 8'h3F);
    check("watchdog", watchdog_enable_bit, 1'h0);
    axi_wr(ADDR_BUS_FORMAT, 8'hFF, RESP_OKAY);
    axi_rd(ADDR_BUS_FORMAT, 8'hF6);
    check("alt", strobe_alt_function, 1'h1);
    check("hidrv", high_drive_select, 1'h1);
    axi_wr(ADDR_SEG_STRETCH, 8'h70, RESP_OKAY);
    check("save", segment_save_enable, 1'h1);
    check("remap", page_pointer_remap, 1'h1);
    check("memory_select_bit", memory_select_bit, 1'h1);
    axi_wr(12'h004, 8'h11, RESP_SLVERR);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      {fmt, second_strobe_enable, las, uas} = 6'($random(seed));
      {uds, lds} = 6'($random(seed));
      a = 22'($random(seed));
      d = 8'($random(seed));
      cfg();
      mem_acc(a, '1, '1, d, '0);
      mem_acc(a, '0, '1, d, '0);
    end
    $display("stretch and format test done");
    {las, uas, lds, uds} = '0;
    cfg();
    external_wait_enable <= '1;
    mem_acc(a, '0, '1, d, '1);
    external_wait_enable <= '0;
    $display("wait test done");
    mem_acc(a, '0, '0, d, '0);
    tog = '1;
    internal_protect_off <= '1;
    cfg();
    mem_acc(a, '0, '0, d, '0);
    $display("internal test done");
    wrap_up();
  end
endmodule
